// ===== hw/pp_port_mux.sv
// Port A/B pin control, alternate-function sharing and register slave
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "pp_regs.svh"

module pp_port_mux
  import pp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:2] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_access_i,
  input  wire logic [15:0] ext_addr_i,
  input  wire logic [15:0] alt_data_i,
  input  wire logic [15:0] pa_pin_i,
  output logic      [15:0] pa_out_o,
  output logic      [15:0] pa_oe_o,
  output logic      [15:0] pa_in_o,
  output logic      [3:0]  cap_o,
  output logic             demux_act_o,
  input  wire logic [15:0] pb_pin_i,
  output logic      [15:0] pb_out_o,
  output logic      [15:0] pb_oe_o,
  output logic      [15:0] pb_in_o
);

  localparam logic [3:0] CAP_LAST = 4'(`PP_CAP_CYC - 1);

  // ========================================================================
  // Helpers
  function automatic pp_reg_type dec(input logic [15:0] idx);
    case (idx)
      `PP_IDX_PWM:    dec = PP_R_PWM;
      `PP_IDX_SER:    dec = PP_R_SER;
      `PP_IDX_CFG:    dec = PP_R_CFG;
      `PP_IDX_PALD:   dec = PP_R_PALD;
      `PP_IDX_PAHD:   dec = PP_R_PAHD;
      `PP_IDX_PALDIR: dec = PP_R_PALDIR;
      `PP_IDX_PAHDIR: dec = PP_R_PAHDIR;
      `PP_IDX_PBD:    dec = PP_R_PBD;
      `PP_IDX_PBDIR:  dec = PP_R_PBDIR;
      `PP_IDX_PBOD:   dec = PP_R_PBOD;
      default:        dec = PP_R_NONE;
    endcase
  endfunction : dec

  // Byte-lane merge; masked-off bits stay zero
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0]  sel,
                                         input logic [15:0] msk);
    logic [15:0] be;
    be = {{8{sel[1]}}, {8{sel[0]}}} & msk;
    wmerge = ((old & ~be) | (wd & be)) & msk;
  endfunction : wmerge

  // ========================================================================
  // State
  logic [15:0] cfg_ff, pwm_ff, ser_ff, pa_lat_ff, pa_dir_ff;
  logic [15:0] pb_dat_ff, pb_dir_ff, pb_od_ff, rdat_ff;
  logic        ack_ff;
  logic [15:0] nxt_cfg, nxt_pwm, nxt_ser, nxt_pa_lat, nxt_pa_dir;
  logic [15:0] nxt_pb_dat, nxt_pb_dir, nxt_pb_od, nxt_rdat;
  logic        nxt_ack;
  logic [3:0]  cap_ff, nxt_cap, cap_cnt_ff, nxt_cap_cnt;

  pp_reg_type  sel_reg;
  logic        req, wr;
  logic        pwm_vis, ser_vis, any_ext, demux_act;
  logic [15:0] ea_dat, ea_dir, ea_od, pa_rd, pb_rd, tmp, pb_in_raw;

  assign sel_reg = dec(wb_adr_i);
  assign req     = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr      = req & wb_we_i;

  assign pwm_vis = cfg_ff[`PP_CFG_GLOBAL] & cfg_ff[`PP_CFG_PWM]; // see R4
  assign ser_vis = cfg_ff[`PP_CFG_GLOBAL] & cfg_ff[`PP_CFG_ASC]; // see R20
  // Any extension peripheral claims pins the address bus would need
  assign any_ext = cfg_ff[`PP_CFG_GLOBAL] &
                   (cfg_ff[`PP_CFG_ASC] | cfg_ff[`PP_CFG_SSC] |
                    cfg_ff[`PP_CFG_I2C] | cfg_ff[`PP_CFG_PWM]); // see R14
  assign demux_act = cfg_ff[`PP_CFG_DEMUX] & ~any_ext; // see R9 R10

  // ========================================================================
  // Effective port A line configuration
  always_comb begin
    // Peripheral outputs idle high, so gating keeps the latch level; see R16
    ea_dat = pa_lat_ff & alt_data_i;
    ea_dir = pa_dir_ff; // see R13
    ea_od  = '0;        // see R5
    if (pwm_vis) begin
      for (int y = 0; y < 4; y++) begin
        ea_od[y]  = pwm_ff[3*y+2];                 // see R6
        ea_dat[y] = pwm_ff[3*y+1] & alt_data_i[y]; // see R7
        ea_dir[y] = pwm_ff[3*y];                   // see R8
      end
    end
    if (ser_vis) begin
      ea_od[4]  = ser_ff[5];                 // see R1
      ea_od[5]  = ser_ff[2];                 // see R1
      ea_dat[4] = ser_ff[4] & alt_data_i[4]; // see R2
      ea_dat[5] = ser_ff[1] & alt_data_i[5]; // see R2
      ea_dir[4] = ser_ff[3];                 // see R3
      ea_dir[5] = ser_ff[0];                 // see R3
    end
    if (demux_act) begin
      // Bus controller owns the whole port; direction register keeps its value
      ea_dat = pa_lat_ff;
      ea_dir = 16'hFFFF; // see R11
      ea_od  = '0;
    end
  end

  pp_pin_cell #(.W(16)) u_pa (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dat_i (ea_dat),
    .dir_i (ea_dir),
    .od_i  (ea_od),
    .pin_i (pa_pin_i),
    .out_o (pa_out_o),
    .oe_o  (pa_oe_o),
    .in_o  (pa_in_o)
  );

  // Lines 1..0 of port B do not exist: never driven, read as zero
  pp_pin_cell #(.W(16)) u_pb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dat_i (pb_dat_ff),
    .dir_i (pb_dir_ff),          // see R19
    .od_i  (pb_od_ff),           // see R17
    .pin_i (pb_pin_i),
    .out_o (pb_out_o),
    .oe_o  (pb_oe_o),
    .in_o  (pb_in_raw)
  );

  // Mask after the synchroniser so the raw pin meets two flops first
  assign pb_in_o = pb_in_raw & `PP_MSK_PB;

  // Reads show the pin on input lines and the latch on output lines
  assign pa_rd = (pa_lat_ff & ea_dir) | (pa_in_o & ~ea_dir);
  assign pb_rd = (pb_dat_ff & pb_dir_ff) | (pb_in_o & ~pb_dir_ff);

  // ========================================================================
  // Register slave: answer one cycle after the request
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_pwm    = pwm_ff;
    nxt_ser    = ser_ff;
    nxt_pa_lat = pa_lat_ff;
    nxt_pa_dir = pa_dir_ff;
    nxt_pb_dat = pb_dat_ff;
    nxt_pb_dir = pb_dir_ff;
    nxt_pb_od  = pb_od_ff;
    nxt_ack    = req;
    nxt_rdat   = rdat_ff;
    tmp        = '0;
    if (req) begin
      nxt_rdat = '0; // see R21
      case (sel_reg)
        PP_R_PWM:    nxt_rdat = pwm_vis ? pwm_ff : '0; // see R4
        PP_R_SER:    nxt_rdat = ser_vis ? ser_ff : '0; // see R20
        PP_R_CFG:    nxt_rdat = cfg_ff;
        PP_R_PALD:   nxt_rdat = {8'h00, pa_rd[7:0]};
        PP_R_PAHD:   nxt_rdat = {8'h00, pa_rd[15:8]};
        PP_R_PALDIR: nxt_rdat = {8'h00, pa_dir_ff[7:0]};
        PP_R_PAHDIR: nxt_rdat = {8'h00, pa_dir_ff[15:8]};
        PP_R_PBD:    nxt_rdat = pb_rd & `PP_MSK_PB;
        PP_R_PBDIR:  nxt_rdat = pb_dir_ff;
        PP_R_PBOD:   nxt_rdat = pb_od_ff;
        default:     nxt_rdat = '0;
      endcase
    end
    if (wr) begin
      case (sel_reg)
        PP_R_PWM: begin
          if (pwm_vis) begin
            nxt_pwm = wmerge(pwm_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                             `PP_MSK_PWM); // see R4
          end
        end
        PP_R_SER: begin
          if (ser_vis) begin
            nxt_ser = wmerge(ser_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                             `PP_MSK_SER); // see R20
          end
        end
        PP_R_CFG: begin
          nxt_cfg = wmerge(cfg_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                           `PP_MSK_CFG);
        end
        PP_R_PALD: begin
          tmp = wmerge({8'h00, pa_lat_ff[7:0]}, wb_dat_i[15:0],
                       wb_sel_i[1:0], `PP_MSK_BYTE);
          nxt_pa_lat[7:0] = tmp[7:0];
        end
        PP_R_PAHD: begin
          tmp = wmerge({8'h00, pa_lat_ff[15:8]}, wb_dat_i[15:0],
                       wb_sel_i[1:0], `PP_MSK_BYTE);
          nxt_pa_lat[15:8] = tmp[7:0];
        end
        PP_R_PALDIR: begin
          tmp = wmerge({8'h00, pa_dir_ff[7:0]}, wb_dat_i[15:0],
                       wb_sel_i[1:0], `PP_MSK_BYTE);
          nxt_pa_dir[7:0] = tmp[7:0];
        end
        PP_R_PAHDIR: begin
          tmp = wmerge({8'h00, pa_dir_ff[15:8]}, wb_dat_i[15:0],
                       wb_sel_i[1:0], `PP_MSK_BYTE);
          nxt_pa_dir[15:8] = tmp[7:0];
        end
        PP_R_PBD: begin
          nxt_pb_dat = wmerge(pb_dat_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                              `PP_MSK_PB); // see R18
        end
        PP_R_PBDIR: begin
          nxt_pb_dir = wmerge(pb_dir_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                              `PP_MSK_PB); // see R19
        end
        PP_R_PBOD: begin
          nxt_pb_od = wmerge(pb_od_ff, wb_dat_i[15:0], wb_sel_i[1:0],
                             `PP_MSK_PB); // see R17
        end
        default: begin
          nxt_cfg = cfg_ff;
        end
      endcase
    end
    // Address load wins over a software write, which must not happen anyway
    if (demux_act && ext_access_i) begin
      nxt_pa_lat = ext_addr_i; // see R11 R12
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff    <= `PP_RST_16;
      pwm_ff    <= `PP_RST_16;
      ser_ff    <= `PP_RST_16;
      pa_lat_ff <= `PP_RST_16;
      pa_dir_ff <= `PP_RST_16;
      pb_dat_ff <= `PP_RST_16;
      pb_dir_ff <= `PP_RST_16;
      pb_od_ff  <= `PP_RST_16;
      rdat_ff   <= `PP_RST_16;
      ack_ff    <= 1'b0;
    end else begin
      cfg_ff    <= nxt_cfg;
      pwm_ff    <= nxt_pwm;
      ser_ff    <= nxt_ser;
      pa_lat_ff <= nxt_pa_lat;
      pa_dir_ff <= nxt_pa_dir;
      pb_dat_ff <= nxt_pb_dat;
      pb_dir_ff <= nxt_pb_dir;
      pb_od_ff  <= nxt_pb_od;
      rdat_ff   <= nxt_rdat;
      ack_ff    <= nxt_ack;
    end
  end

  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = {16'h0000, rdat_ff};
  assign demux_act_o = demux_act;
  assign cap_o       = cap_ff;

  // ========================================================================
  // Capture and interrupt sampling of high lines 7..4
  always_comb begin
    nxt_cap     = cap_ff;
    nxt_cap_cnt = cap_cnt_ff + 4'h1;
    if (cap_cnt_ff == CAP_LAST) begin
      nxt_cap_cnt = 4'h0;
      nxt_cap     = pa_in_o[15:12]; // see R15
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_ff     <= 4'h0;
      cap_cnt_ff <= 4'h0;
    end else begin
      cap_ff     <= nxt_cap;
      cap_cnt_ff <= nxt_cap_cnt;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_latency_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after request");
  pwm_hidden_a: assert property ( // see R4
    req && !wb_we_i && sel_reg == PP_R_PWM && !pwm_vis
    |=> wb_dat_o == 32'h0000_0000)
    else $error("hidden pwm control register read nonzero");
  pwm_no_od_a: assert property (!pwm_vis |-> ea_od[3:0] == 4'h0) // see R5
    else $error("open drain on pwm lines while control hidden");
  ser_no_od_a: assert property (!ser_vis |-> ea_od[5:4] == 2'b00) // see R20
    else $error("open drain on serial lines while control hidden");
  pwm_map_a: assert property ( // see R7
    pwm_vis && !demux_act |-> ea_dir[3] == pwm_ff[9] &&
    ea_od[2] == pwm_ff[8] && ea_dat[0] == (pwm_ff[1] & alt_data_i[0]))
    else $error("pwm control bits mapped to wrong lines");
  ser_map_a: assert property ( // see R1
    ser_vis && !demux_act |-> ea_od[4] == ser_ff[5] &&
    ea_dir[5] == ser_ff[0] && ea_dat[5] == (ser_ff[1] & alt_data_i[5]))
    else $error("serial control bits mapped to wrong lines");
  demux_drive_a: assert property (demux_act |-> pa_oe_o == 16'hFFFF) // see R9
    else $error("address bus not driven on all lines");
  demux_load_a: assert property ( // see R11
    demux_act && ext_access_i |=> pa_lat_ff == $past(ext_addr_i))
    else $error("address not loaded into port latch");
  demux_block_a: assert property (any_ext |-> !demux_act_o) // see R14
    else $error("demux bus active with extension peripheral enabled");
  dir_restore_a: assert property ( // see R13
    $fell(demux_act) |-> ea_dir[15:6] == pa_dir_ff[15:6])
    else $error("direction register not restored after bus mode");
  pb_reserved_a: assert property ( // see R18
    pb_dat_ff[1:0] == 2'b00 && pb_oe_o[1:0] == 2'b00)
    else $error("port b reserved lines active");
  cap_period_a: assert property ( // see R15
    cap_cnt_ff == CAP_LAST |=> cap_o == $past(pa_in_o[15:12]) &&
    cap_cnt_ff == 4'h0)
    else $error("capture sample taken at wrong time");

endmodule : pp_port_mux

// ===== include/pp_regs.svh
// Register indices, field positions, reset values and timing counts
// Functional notes
// R1: Serial control bits 5 and 2 pick push/pull or open drain, lines 4, 5.
// R2: Serial control bits 4 and 1 hold output data for lines 4 and 5.
// R3: Serial control bits 3 and 0 set direction of lines 4 and 5.
// R4: PWM pin control register visible only with global and PWM enables set.
// R5: PWM control hidden: standard low registers drive lines 0-3, no open drain.
// R6: PWM control bits 11, 8, 5, 2 pick open drain for lines 3..0.
// R7: PWM control bits 10, 7, 4, 1 hold output data for lines 3..0.
// R8: PWM control bits 9, 6, 3, 0 set direction for lines 3..0.
// R9: Demultiplexed bus mode uses all sixteen port A lines as address bus.
// R10: Multiplexed bus modes leave port A free for general purpose use.
// R11: In demux mode the bus controller owns direction and loads the latch.
// R12: Software must not write port A latch while bus mode is on.
// R13: Bus modes off: last written direction register applies again.
// R14: Any enabled extension peripheral blocks the demultiplexed bus function.
// R15: High lines 7..4 feed capture and interrupt inputs, sampled periodically.
// R16: Port A pins are shared with serial, I2C, sync serial and PWM units.
// R17: Port B has 14 lines with direction and open drain per line.
// R18: Port B data bits 15..2 read/write, bits 1..0 absent, reset zero.
// R19: Port B direction bit 0 is high-impedance input, 1 is output.
// R20: Serial control visible only with global and serial enables set.
// R21: Reserved bits read zero and ignore writes.
`ifndef PP_REGS_SVH
`define PP_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define PP_IDX_PWM    16'hEC80
`define PP_IDX_SER    16'hE980
`define PP_IDX_CFG    16'hE000
`define PP_IDX_PALD   16'hFF04
`define PP_IDX_PAHD   16'hFF06
`define PP_IDX_PALDIR 16'hF104
`define PP_IDX_PAHDIR 16'hF106
`define PP_IDX_PBD    16'hFFC0
`define PP_IDX_PBDIR  16'hFFC2
`define PP_IDX_PBOD   16'hF1C2

// ==========================================================================
// Implemented-bit masks and reset values
`define PP_MSK_PWM  16'h0FFF
`define PP_MSK_SER  16'h003F
`define PP_MSK_CFG  16'h003F
`define PP_MSK_BYTE 16'h00FF
`define PP_MSK_PB   16'hFFFC
`define PP_RST_16   16'h0000

// ==========================================================================
// Configuration register fields
`define PP_CFG_GLOBAL 0
`define PP_CFG_ASC    1
`define PP_CFG_SSC    2
`define PP_CFG_I2C    3
`define PP_CFG_PWM    4
`define PP_CFG_DEMUX  5

// ==========================================================================
// Capture sampling period, rounded up to whole clocks
`define PP_CLK_MHZ  25
`define PP_CAP_PS   83340
`define PP_CAP_CYC  ((`PP_CAP_PS * `PP_CLK_MHZ + 999999) / 1000000)

`endif

// ===== include/pp_pkg.sv
// Types shared by the port pin logic
package pp_pkg;

  // ========================================================================
  // Register selection
  typedef enum logic [3:0] {
    PP_R_NONE   = 4'h0,
    PP_R_PWM    = 4'h1,
    PP_R_SER    = 4'h2,
    PP_R_CFG    = 4'h3,
    PP_R_PALD   = 4'h4,
    PP_R_PAHD   = 4'h5,
    PP_R_PALDIR = 4'h6,
    PP_R_PAHDIR = 4'h7,
    PP_R_PBD    = 4'h8,
    PP_R_PBDIR  = 4'h9,
    PP_R_PBOD   = 4'hA
  } pp_reg_type;

endpackage : pp_pkg

// ===== hw/pp_pin_cell.sv
// Pad driver and input synchroniser for a group of port lines
`timescale 1ns/1ps

module pp_pin_cell #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] dat_i,
  input  wire logic [W-1:0] dir_i,
  input  wire logic [W-1:0] od_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] out_o,
  output logic      [W-1:0] oe_o,
  output logic      [W-1:0] in_o
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;

  // ========================================================================
  // Drivers: open drain only ever pulls low
  assign out_o = dat_i;
  assign oe_o  = dir_i & ~(od_i & dat_i);
  assign in_o  = s2_ff;

  // ========================================================================
  // Two-stage synchroniser
  always_comb begin
    nxt_s1 = pin_i;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

endmodule : pp_pin_cell

// ===== verification/pp_pin_partner.sv
// Model of the outside world at the pins of port A and port B
`timescale 1ns/1ps

module pp_pin_partner (
  input  wire logic [15:0] pa_out_i,
  input  wire logic [15:0] pa_oe_i,
  input  wire logic [15:0] pb_out_i,
  input  wire logic [15:0] pb_oe_i,
  input  wire logic [15:0] ext_a_i,
  input  wire logic [15:0] ext_b_i,
  output logic      [15:0] pa_pin_o,
  output logic      [15:0] pb_pin_o
);
  // ========================================================================
  // Pin levels
  // A released line, open drain included, shows the external driver level
  assign pa_pin_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & ext_a_i);
  assign pb_pin_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & ext_b_i);
endmodule : pp_pin_partner

// ===== verification/pp_port_mux_test.sv
// Self-checking testbench of the port pin control block
`timescale 1ns/1ps
`include "pp_regs.svh"

module pp_port_mux_test;
  import pp_pkg::*;
  // ========================================================================
  // Signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ext_acc = 1'b0;
  logic [15:0] ext_addr = 16'h0000, alt = 16'hFFFF;
  logic [15:0] ext_a = 16'h0000, ext_b = 16'h0000;
  logic [15:0] pa_pin, pa_out, pa_oe, pa_in, pb_pin, pb_out, pb_oe, pb_in;
  logic [3:0]  cap;
  logic        demux_act;
  logic [31:0] lfsr = 32'h00015EE7;
  int          n_errors = 0;
  int          check_count = 0;
  logic [15:0] m [10];
  localparam logic [15:0] IDX [10] = '{`PP_IDX_PWM, `PP_IDX_SER,
    `PP_IDX_CFG, `PP_IDX_PALD, `PP_IDX_PAHD, `PP_IDX_PALDIR,
    `PP_IDX_PAHDIR, `PP_IDX_PBD, `PP_IDX_PBDIR, `PP_IDX_PBOD};
  localparam logic [15:0] MSK [10] = '{`PP_MSK_PWM, `PP_MSK_SER,
    `PP_MSK_CFG, `PP_MSK_BYTE, `PP_MSK_BYTE, `PP_MSK_BYTE, `PP_MSK_BYTE,
    `PP_MSK_PB, `PP_MSK_PB, `PP_MSK_PB};

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  pp_port_mux i_pp_port_mux (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_access_i(ext_acc),
    .ext_addr_i(ext_addr), .alt_data_i(alt), .pa_pin_i(pa_pin),
    .pa_out_o(pa_out), .pa_oe_o(pa_oe), .pa_in_o(pa_in), .cap_o(cap),
    .demux_act_o(demux_act), .pb_pin_i(pb_pin), .pb_out_o(pb_out),
    .pb_oe_o(pb_oe), .pb_in_o(pb_in));

  pp_pin_partner i_pp_pin_partner (
    .pa_out_i(pa_out), .pa_oe_i(pa_oe), .pb_out_i(pb_out),
    .pb_oe_i(pb_oe), .ext_a_i(ext_a), .ext_b_i(ext_b),
    .pa_pin_o(pa_pin), .pb_pin_o(pb_pin));

  // ========================================================================
  // Model and helpers
  function automatic logic [15:0] rnd();
    lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h80200003 : lfsr >> 1;
    return lfsr[15:0];
  endfunction : rnd

  function automatic logic vis(int i);
    if (i == 0) return m[2][0] & m[2][4];
    if (i == 1) return m[2][0] & m[2][1];
    return 1'b1;
  endfunction : vis

  function automatic logic demux();
    return m[2][5] & ~(m[2][0] & (|m[2][4:1]));
  endfunction : demux

  // Returns open drain, direction and output data of port A
  function automatic logic [47:0] exp_a();
    logic [15:0] d, r, o;
    d = {m[4][7:0], m[3][7:0]};
    r = {m[6][7:0], m[5][7:0]};
    o = 16'h0000;
    if (vis(1)) begin
      {o[4], d[4], r[4]} = m[1][5:3];
      {o[5], d[5], r[5]} = m[1][2:0];
    end
    if (vis(0)) begin
      for (int k = 0; k < 4; k++) {o[k], d[k], r[k]} = m[0][3*k+:3];
    end
    if (demux()) begin
      r = 16'hFFFF;
      o = 16'h0000;
      d = {m[4][7:0], m[3][7:0]};
    end
    return {o, r, d};
  endfunction : exp_a

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    r = wb_dat_o[15:0];
    chk(wb_dat_o[31:16], 16'h0000);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task automatic wr(input int i, input logic [15:0] v);
    logic [15:0] r;
    xfer(1'b1, IDX[i], v, r);
    if (vis(i)) m[i] = v & MSK[i];
  endtask : wr

  // Data reads show the latch on output lines and the pin on input lines
  task automatic rd(input int i);
    logic [15:0] r, x, dr;
    logic [47:0] e;
    e = exp_a();
    dr = e[31:16];
    x = vis(i) ? m[i] : 16'h0000;
    if (i == 3) x = {8'h00, (x[7:0] & dr[7:0]) |
                            (ext_a[7:0] & ~dr[7:0])};
    if (i == 4) x = {8'h00, (x[7:0] & dr[15:8]) |
                            (ext_a[15:8] & ~dr[15:8])};
    if (i == 7) x = ((x & m[8]) | (ext_b & ~m[8])) & 16'hFFFC;
    xfer(1'b0, IDX[i], 16'h0000, r);
    chk(r, x);
  endtask : rd

  task automatic chk_pins();
    logic [47:0] e;
    e = exp_a();
    @(posedge clk_i);
    chk(pa_oe, e[31:16] & ~(e[47:32] & e[15:0] & alt));
    chk(pa_oe, e[31:16] & ~(e[47:32] & e[15:0] & alt));
    chk(pa_out, e[15:0] & alt);
    chk({15'h0000, demux_act}, {15'h0000, demux()});
    chk(pb_oe, m[8] & ~(m[9] & m[7]));
    chk(pb_out & 16'hFFFC, m[7]);
  endtask : chk_pins

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  // ========================================================================
  // Scenarios
  initial begin
    logic [15:0] r, a;
    logic [7:0]  ctab [5];
    ctab = '{8'h00, 8'h03, 8'h11, 8'h13, 8'h12};
    for (int i = 0; i < 10; i++) m[i] = 16'h0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd(i);
    xfer(1'b1, 16'h1234, 16'hFFFF, r);
    xfer(1'b0, 16'h1234, 16'h0000, r);
    chk(r, 16'h0000);
    wr(0, 16'hFFFF);
    wr(1, 16'hFFFF);
    wr(7, 16'hFFFF);
    for (int i = 0; i < 10; i++) rd(i);
    chk_pins();
    // Visible and hidden extension controls over random pin settings
    for (int j = 0; j < 10; j++) begin
      alt <= rnd();
      wr(2, {8'h00, ctab[j % 5]} | (rnd() & 16'h000C));
      for (int i = 0; i < 10; i++) if (i != 2) wr(i, rnd());
      for (int i = 0; i < 10; i++) rd(i);
      chk_pins();
    end
    // Demultiplexed bus owns port A; latch writes are avoided meanwhile
    alt <= 16'hFFFF;
    wr(2, 16'h0020);
    a = rnd();
    ext_addr <= a;
    ext_acc <= 1'b1;
    @(posedge clk_i);
    ext_acc <= 1'b0;
    m[3] = {8'h00, a[7:0]};
    m[4] = {8'h00, a[15:8]};
    chk_pins();
    chk(pa_out, a);
    for (int k = 1; k < 5; k++) begin
      wr(2, 16'h0021 | (16'h0001 << k));
      chk_pins();
    end
    wr(2, 16'h003E);
    chk_pins();
    // Multiplexed bus: external access leaves port A alone
    wr(2, 16'h0000);
    ext_addr <= ~a;
    ext_acc <= 1'b1;
    @(posedge clk_i);
    ext_acc <= 1'b0;
    chk_pins();
    // Inputs reach peripherals and the capture lines
    for (int i = 3; i < 10; i++) wr(i, 16'h0000);
    for (int j = 0; j < 3; j++) begin
      ext_a <= rnd();
      ext_b <= rnd();
      repeat (8) @(posedge clk_i);
      chk({12'h000, cap}, {12'h000, ext_a[15:12]});
      chk(pa_in, ext_a);
      chk(pb_in, ext_b & 16'hFFFC);
    end
    end_sim();
  end
endmodule : pp_port_mux_test
